// file: t3cs_defines.vh
// Register indices, field positions, reset values and counts of the timer 3 control block.
`ifndef T3CS_DEFINES_VH
`define T3CS_DEFINES_VH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define T3CS_IDX_CTRL       10'h091
`define T3CS_IDX_RELOAD_LO  10'h092
`define T3CS_IDX_RELOAD_HI  10'h093
`define T3CS_IDX_COUNT_LO   10'h094
`define T3CS_IDX_COUNT_HI   10'h095
`define T3CS_IDX_CLK_SEL    10'h096
`define T3CS_IDX_IRQ_STAT   10'h097
`define T3CS_IDX_IRQ_MASK   10'h098

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define T3CS_HI_FLAG_BIT    7
`define T3CS_LO_FLAG_BIT    6
`define T3CS_LO_IRQ_EN_BIT  5
`define T3CS_CAPTURE_BIT    4
`define T3CS_SPLIT_BIT      3
`define T3CS_RUN_BIT        2
`define T3CS_EXT_CLK_BIT    0

// ----------------------------------------------------------------------------
// Clock select, interrupt status and mask fields
// ----------------------------------------------------------------------------
`define T3CS_LO_CLK_SEL_BIT 0
`define T3CS_HI_CLK_SEL_BIT 1
`define T3CS_IRQ_HI_BIT     0
`define T3CS_IRQ_LO_BIT     1

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define T3CS_RESET_BYTE     8'h00
`define T3CS_BYTE_MAX       8'hFF
`define T3CS_WORD_MAX       16'hFFFF
`define T3CS_DIV12_LAST     4'hB
`define T3CS_DIV8_LAST      3'h7
`define T3CS_RESP_OKAY      2'h0
`define T3CS_RESP_SLVERR    2'h2

`endif

// file: t3cs_top.v
// Timer 3 control and status block with its counter, reload pair and AXI4-Lite slave.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "t3cs_defines.vh"

module t3cs_top (
  input  wire        CLOCK_I,
  input  wire        RST_B_I,
  input  wire        EXT_OSC_I,
  input  wire [11:0] S_AXI_AWADDR_I,
  input  wire        S_AXI_AWVALID_I,
  output reg         S_AXI_AWREADY_O,
  input  wire [31:0] S_AXI_WDATA_I,
  input  wire [3:0]  S_AXI_WSTRB_I,
  input  wire        S_AXI_WVALID_I,
  output reg         S_AXI_WREADY_O,
  output reg  [1:0]  S_AXI_BRESP_O,
  output reg         S_AXI_BVALID_O,
  input  wire        S_AXI_BREADY_I,
  input  wire [11:0] S_AXI_ARADDR_I,
  input  wire        S_AXI_ARVALID_I,
  output reg         S_AXI_ARREADY_O,
  output reg  [31:0] S_AXI_RDATA_O,
  output reg  [1:0]  S_AXI_RRESP_O,
  output reg         S_AXI_RVALID_O,
  input  wire        S_AXI_RREADY_I,
  output reg         IRQ_O
);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg        hi_overflow_flag;
  reg        lo_overflow_flag;
  reg        lo_overflow_irq_en;
  reg        capture_mode_en;
  reg        split_mode_sel;
  reg        run_ctl;
  reg        ext_clk_sel;
  reg        lo_byte_clk_sel;
  reg        hi_byte_clk_sel;
  reg  [7:0] count_low_byte;
  reg  [7:0] count_high_byte;
  reg  [7:0] reload_low_byte;
  reg  [7:0] reload_high_byte;
  reg  [1:0] irq_status;
  reg  [1:0] irq_mask;
  reg  [9:0] aw_idx;
  reg        aw_full;
  reg  [7:0] w_byte;
  reg        w_lane0;
  reg        w_full;
  reg  [7:0] rd_byte;
  reg        rd_hit;
  reg  [3:0] div12_cnt;
  reg        tick12;
  reg        ext_meta;
  reg        ext_sync;
  reg        ext_prev;
  reg  [2:0] div8_cnt;
  reg        ext_tick;
  reg        lo_tick;
  reg        hi_tick;
  reg  [7:0] next_count_low_byte;
  reg  [7:0] next_count_high_byte;
  reg        hi_event;
  reg        lo_event;
  wire       capture_event;
  wire [9:0] ar_idx      = S_AXI_ARADDR_I[11:2];
  wire       wr_hit      = (aw_idx >= `T3CS_IDX_CTRL) && (aw_idx <= `T3CS_IDX_IRQ_MASK);
  wire       write_go    = aw_full & w_full & ~S_AXI_BVALID_O;
  wire       wr_ctrl     = write_go & w_lane0 & (aw_idx == `T3CS_IDX_CTRL);
  wire       wr_rel_lo   = write_go & w_lane0 & (aw_idx == `T3CS_IDX_RELOAD_LO);
  wire       wr_rel_hi   = write_go & w_lane0 & (aw_idx == `T3CS_IDX_RELOAD_HI);
  wire       wr_cnt_lo   = write_go & w_lane0 & (aw_idx == `T3CS_IDX_COUNT_LO);
  wire       wr_cnt_hi   = write_go & w_lane0 & (aw_idx == `T3CS_IDX_COUNT_HI);
  wire       wr_clk_sel  = write_go & w_lane0 & (aw_idx == `T3CS_IDX_CLK_SEL);
  wire       wr_irq_stat = write_go & w_lane0 & (aw_idx == `T3CS_IDX_IRQ_STAT);
  wire       wr_irq_mask = write_go & w_lane0 & (aw_idx == `T3CS_IDX_IRQ_MASK);

  // --------------------------------------------------------------------------
  // Timebase
  // --------------------------------------------------------------------------
  // The oscillator pin is asynchronous; only ext_sync is read past the first stage.
  // Prescaler ticks
  always @(posedge CLOCK_I) begin
    if (!RST_B_I) begin
      div12_cnt <= 4'h0;
      tick12    <= 1'b0;
      ext_meta  <= 1'b0;
      ext_sync  <= 1'b0;
      ext_prev  <= 1'b0;
      div8_cnt  <= 3'h0;
      ext_tick  <= 1'b0;
    end else begin
      tick12    <= (div12_cnt == `T3CS_DIV12_LAST);
      div12_cnt <= (div12_cnt == `T3CS_DIV12_LAST) ? 4'h0 : div12_cnt + 4'h1;
      ext_meta  <= EXT_OSC_I;
      ext_sync  <= ext_meta;
      ext_prev  <= ext_sync;
      ext_tick  <= 1'b0;
      if (ext_sync & ~ext_prev) begin
        div8_cnt <= div8_cnt + 3'h1;
        // The divided clock falls as the count wraps, which is also its tick.
        ext_tick <= (div8_cnt == `T3CS_DIV8_LAST);
      end
    end
  end

  assign capture_event = capture_mode_en & ext_tick;

  // --------------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------------
  always @* begin
    lo_tick = lo_byte_clk_sel ? 1'b1 : (ext_clk_sel ? ext_tick : tick12);
    hi_tick = hi_byte_clk_sel ? 1'b1 : (ext_clk_sel ? ext_tick : tick12);
    next_count_low_byte  = count_low_byte;
    next_count_high_byte = count_high_byte;
    hi_event = 1'b0;
    lo_event = 1'b0;
    if (!split_mode_sel) begin
      if (run_ctl & lo_tick) begin
        if ({count_high_byte, count_low_byte} == `T3CS_WORD_MAX) begin
          next_count_low_byte  = reload_low_byte;
          next_count_high_byte = reload_high_byte;
          hi_event = 1'b1;
          lo_event = 1'b1;
        end else begin
          next_count_low_byte  = count_low_byte + 8'h01;
          next_count_high_byte = count_high_byte + {7'h00, count_low_byte == `T3CS_BYTE_MAX};
          lo_event = (count_low_byte == `T3CS_BYTE_MAX);
        end
      end
    end else begin
      if (lo_tick) begin
        lo_event            = (count_low_byte == `T3CS_BYTE_MAX);
        next_count_low_byte = lo_event ? reload_low_byte : count_low_byte + 8'h01;
      end
      if (run_ctl & hi_tick) begin
        hi_event             = (count_high_byte == `T3CS_BYTE_MAX);
        next_count_high_byte = hi_event ? reload_high_byte : count_high_byte + 8'h01;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Control, counter and reload registers
  // --------------------------------------------------------------------------
  always @(posedge CLOCK_I) begin
    if (!RST_B_I) begin
      hi_overflow_flag   <= 1'b0;
      lo_overflow_flag   <= 1'b0;
      lo_overflow_irq_en <= 1'b0;
      capture_mode_en    <= 1'b0;
      split_mode_sel     <= 1'b0;
      run_ctl            <= 1'b0;
      ext_clk_sel        <= 1'b0;
      lo_byte_clk_sel    <= 1'b0;
      hi_byte_clk_sel    <= 1'b0;
      count_low_byte     <= `T3CS_RESET_BYTE;
      count_high_byte    <= `T3CS_RESET_BYTE;
      reload_low_byte    <= `T3CS_RESET_BYTE;
      reload_high_byte   <= `T3CS_RESET_BYTE;
    end else begin
      if (wr_ctrl) begin
        lo_overflow_irq_en <= w_byte[`T3CS_LO_IRQ_EN_BIT];
        capture_mode_en    <= w_byte[`T3CS_CAPTURE_BIT];
        split_mode_sel     <= w_byte[`T3CS_SPLIT_BIT];
        run_ctl            <= w_byte[`T3CS_RUN_BIT];
        ext_clk_sel        <= w_byte[`T3CS_EXT_CLK_BIT];
      end
      // Only software clears; a set in the same cycle wins.
      if (hi_event | capture_event)
        hi_overflow_flag <= 1'b1;
      else if (wr_ctrl)
        hi_overflow_flag <= w_byte[`T3CS_HI_FLAG_BIT];
      if (lo_event)
        lo_overflow_flag <= 1'b1;
      else if (wr_ctrl)
        lo_overflow_flag <= w_byte[`T3CS_LO_FLAG_BIT];
      if (wr_clk_sel) begin
        lo_byte_clk_sel <= w_byte[`T3CS_LO_CLK_SEL_BIT];
        hi_byte_clk_sel <= w_byte[`T3CS_HI_CLK_SEL_BIT];
      end
      // A software write to a count byte overrides that cycle's increment.
      count_low_byte  <= wr_cnt_lo ? w_byte : next_count_low_byte;
      count_high_byte <= wr_cnt_hi ? w_byte : next_count_high_byte;
      if (capture_event | wr_rel_lo)
        reload_low_byte  <= capture_event ? count_low_byte : w_byte;
      if (capture_event | wr_rel_hi)
        reload_high_byte <= capture_event ? count_high_byte : w_byte;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt status, mask and output
  // --------------------------------------------------------------------------
  always @(posedge CLOCK_I) begin
    if (!RST_B_I) begin
      irq_status <= 2'h0;
      irq_mask   <= 2'h0;
      IRQ_O      <= 1'b0;
    end else begin
      if (wr_irq_mask)
        irq_mask <= w_byte[1:0];
      if (hi_event | capture_event)
        irq_status[`T3CS_IRQ_HI_BIT] <= 1'b1;
      else if (wr_irq_stat & w_byte[`T3CS_IRQ_HI_BIT])
        irq_status[`T3CS_IRQ_HI_BIT] <= 1'b0;
      if (lo_event & lo_overflow_irq_en)
        irq_status[`T3CS_IRQ_LO_BIT] <= 1'b1;
      else if (wr_irq_stat & w_byte[`T3CS_IRQ_LO_BIT])
        irq_status[`T3CS_IRQ_LO_BIT] <= 1'b0;
      IRQ_O <= |(irq_status & irq_mask);
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------------------
  always @(posedge CLOCK_I) begin
    if (!RST_B_I) begin
      aw_idx          <= 10'h000;
      aw_full         <= 1'b0;
      w_byte          <= 8'h00;
      w_lane0         <= 1'b0;
      w_full          <= 1'b0;
      S_AXI_AWREADY_O <= 1'b0;
      S_AXI_WREADY_O  <= 1'b0;
      S_AXI_BVALID_O  <= 1'b0;
      S_AXI_BRESP_O   <= `T3CS_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID_I & S_AXI_AWREADY_O) begin
        aw_idx          <= S_AXI_AWADDR_I[11:2];
        aw_full         <= 1'b1;
        S_AXI_AWREADY_O <= 1'b0;
      end else if (!aw_full) begin
        S_AXI_AWREADY_O <= 1'b1;
      end
      if (S_AXI_WVALID_I & S_AXI_WREADY_O) begin
        w_byte         <= S_AXI_WDATA_I[7:0];
        w_lane0        <= S_AXI_WSTRB_I[0];
        w_full         <= 1'b1;
        S_AXI_WREADY_O <= 1'b0;
      end else if (!w_full) begin
        S_AXI_WREADY_O <= 1'b1;
      end
      if (write_go) begin
        aw_full        <= 1'b0;
        w_full         <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O  <= wr_hit ? `T3CS_RESP_OKAY : `T3CS_RESP_SLVERR;
      end else if (S_AXI_BVALID_O & S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------------
  always @* begin
    rd_hit = 1'b1;
    rd_byte = 8'h00;
    case (ar_idx)
      `T3CS_IDX_CTRL:      rd_byte = {hi_overflow_flag, lo_overflow_flag, lo_overflow_irq_en,
                                      capture_mode_en, split_mode_sel, run_ctl, 1'b0,
                                      ext_clk_sel};
      `T3CS_IDX_RELOAD_LO: rd_byte = reload_low_byte;
      `T3CS_IDX_RELOAD_HI: rd_byte = reload_high_byte;
      `T3CS_IDX_COUNT_LO:  rd_byte = count_low_byte;
      `T3CS_IDX_COUNT_HI:  rd_byte = count_high_byte;
      `T3CS_IDX_CLK_SEL:   rd_byte = {6'h00, hi_byte_clk_sel, lo_byte_clk_sel};
      `T3CS_IDX_IRQ_STAT:  rd_byte = {6'h00, irq_status};
      `T3CS_IDX_IRQ_MASK:  rd_byte = {6'h00, irq_mask};
      default:             rd_hit = 1'b0;
    endcase
  end

  always @(posedge CLOCK_I) begin
    if (!RST_B_I) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O  <= 1'b0;
      S_AXI_RDATA_O   <= 32'h00000000;
      S_AXI_RRESP_O   <= `T3CS_RESP_OKAY;
    end else begin
      if (S_AXI_ARVALID_I & S_AXI_ARREADY_O) begin
        S_AXI_ARREADY_O <= 1'b0;
        S_AXI_RVALID_O  <= 1'b1;
        S_AXI_RDATA_O   <= {24'h000000, rd_byte};
        S_AXI_RRESP_O   <= rd_hit ? `T3CS_RESP_OKAY : `T3CS_RESP_SLVERR;
      end else if (S_AXI_RVALID_O & S_AXI_RREADY_I) begin
        S_AXI_RVALID_O  <= 1'b0;
        S_AXI_ARREADY_O <= 1'b1;
      end else if (!S_AXI_RVALID_O) begin
        S_AXI_ARREADY_O <= 1'b1;
      end
    end
  end

endmodule // t3cs_top

// file: t3cs_top_asserts.sv
// Port-level checker of the timer 3 control block.
`timescale 1ns/100ps
`include "t3cs_defines.vh"
module t3cs_top_asserts (
  input wire logic        CLOCK_I,
  input wire logic        RST_B_I,
  input wire logic        EXT_OSC_I,
  input wire logic [11:0] S_AXI_AWADDR_I,
  input wire logic        S_AXI_AWVALID_I,
  input wire logic        S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0]  S_AXI_WSTRB_I,
  input wire logic        S_AXI_WVALID_I,
  input wire logic        S_AXI_WREADY_O,
  input wire logic [1:0]  S_AXI_BRESP_O,
  input wire logic        S_AXI_BVALID_O,
  input wire logic        S_AXI_BREADY_I,
  input wire logic [11:0] S_AXI_ARADDR_I,
  input wire logic        S_AXI_ARVALID_I,
  input wire logic        S_AXI_ARREADY_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic [1:0]  S_AXI_RRESP_O,
  input wire logic        S_AXI_RVALID_O,
  input wire logic        S_AXI_RREADY_I,
  input wire logic        IRQ_O
);
  logic [9:0] rd_idx;
  logic [1:0] last_flags;
  logic       have_flags;
  wire        rd_ctrl = (rd_idx == `T3CS_IDX_CTRL);
  wire        rd_map  = (rd_idx >= `T3CS_IDX_CTRL) && (rd_idx <= `T3CS_IDX_IRQ_MASK);
  // ---------------------------------------------------------------------------
  // Helper state
  // ---------------------------------------------------------------------------
  // A control write may legally clear the flags, so it forgets the last seen value.
  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I) begin
      rd_idx     <= 10'h000;
      last_flags <= 2'h0;
      have_flags <= 1'b0;
    end else begin
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) rd_idx <= S_AXI_ARADDR_I[11:2];
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_AWADDR_I[11:2] == `T3CS_IDX_CTRL) begin
        have_flags <= 1'b0;
      end else if (S_AXI_RVALID_O && S_AXI_RREADY_I && rd_ctrl) begin
        have_flags <= 1'b1;
        last_flags <= S_AXI_RDATA_O[7:6];
      end
    end
  end
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_B_I);
  sequence wr_taken;
    S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
  endsequence
  sequence rd_taken;
    S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  endsequence
  // The write executes one edge after it is taken, so the answer comes one edge later still.
  AST_WR_ANSWER: assert property (wr_taken |=> !S_AXI_BVALID_O ##1 S_AXI_BVALID_O && !S_AXI_AWREADY_O)
    else $error("write response missing");
  AST_RD_ANSWER: assert property (rd_taken |=> S_AXI_RVALID_O ##0 !S_AXI_ARREADY_O)
    else $error("read response missing");
  AST_B_HOLD: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
    else $error("read data dropped early");
  AST_W_BLOCKED: assert property ($rose(S_AXI_BVALID_O) |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
    else $error("write accepted while response pending");
  AST_UNUSED_BIT: assert property (S_AXI_RVALID_O && rd_ctrl |-> !S_AXI_RDATA_O[1])
    else $error("unused control bit reads one");
  AST_FLAG_STICKY: assert property (S_AXI_RVALID_O && rd_ctrl && have_flags |-> (S_AXI_RDATA_O[7:6] & last_flags) == last_flags)
    else $error("overflow flag cleared without a write");
  AST_RD_UNMAPPED: assert property (S_AXI_RVALID_O && !rd_map |-> S_AXI_RRESP_O == `T3CS_RESP_SLVERR && S_AXI_RDATA_O == 32'h0)
    else $error("unmapped read not refused");
  AST_RD_MAPPED: assert property (S_AXI_RVALID_O && rd_map |-> S_AXI_RRESP_O == `T3CS_RESP_OKAY && S_AXI_RDATA_O[31:8] == 24'h0)
    else $error("mapped read answered wrongly");
endmodule // t3cs_top_asserts

bind t3cs_top t3cs_top_asserts i_chk (.CLOCK_I, .RST_B_I, .EXT_OSC_I, .S_AXI_AWADDR_I,
  .S_AXI_AWVALID_I, .S_AXI_AWREADY_O, .S_AXI_WDATA_I, .S_AXI_WSTRB_I, .S_AXI_WVALID_I,
  .S_AXI_WREADY_O, .S_AXI_BRESP_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I, .S_AXI_ARADDR_I,
  .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RDATA_O, .S_AXI_RRESP_O, .S_AXI_RVALID_O,
  .S_AXI_RREADY_I, .IRQ_O);

// file: t3cs_top_test.sv
// Self-checking testbench of the timer 3 control block.
`timescale 1ns/100ps
`include "t3cs_defines.vh"
module t3cs_top_test;
  localparam logic [9:0] I_CT = `T3CS_IDX_CTRL, I_RL = `T3CS_IDX_RELOAD_LO;
  localparam logic [9:0] I_RH = `T3CS_IDX_RELOAD_HI, I_CL = `T3CS_IDX_COUNT_LO;
  localparam logic [9:0] I_CH = `T3CS_IDX_COUNT_HI, I_CS = `T3CS_IDX_CLK_SEL;
  localparam logic [9:0] I_ST = `T3CS_IDX_IRQ_STAT, I_MK = `T3CS_IDX_IRQ_MASK;
  localparam logic [1:0] OK = `T3CS_RESP_OKAY, ERR = `T3CS_RESP_SLVERR;
  logic        clk = 1'b0, rst_b = 1'b0, ext = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  int          err_total = 0, num_checks = 0, cycles = 0;
  t3cs_top i_dut (.CLOCK_I(clk), .RST_B_I(rst_b), .EXT_OSC_I(ext), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready), .IRQ_O(irq));
  always #2 clk = ~clk;
  // The whole sequence needs well under two thousand cycles; the ceiling leaves ample margin.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  // ---------------------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Ready is registered, so it is judged at the falling edge before the taking edge.
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er = OK);
    logic a, b, ta, tb;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    a = 1'b1;
    b = 1'b1;
    while (a || b) begin
      @(negedge clk);
      ta = a && awready;
      tb = b && wready;
      @(posedge clk);
      if (ta) begin awvalid <= 1'b0; a = 1'b0; end
      if (tb) begin wvalid <= 1'b0; b = 1'b0; end
    end
    @(negedge clk);
    while (!bvalid) @(negedge clk);
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] idx, output logic [31:0] d);
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(negedge clk);
    while (!arready) @(negedge clk);
    @(posedge clk);
    arvalid <= 1'b0;
    @(negedge clk);
    while (!rvalid) @(negedge clk);
    d = rdata;
    chk("rresp", (idx >= I_CT && idx <= I_MK) ? OK : ERR, {30'h0, rresp});
    @(posedge clk);
    rready <= 1'b0;
  endtask
  task automatic rdc(input string what, input logic [9:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    rd(idx, d);
    chk(what, {24'h0, exp}, d);
  endtask
  task automatic chk_irq(input logic exp);
    cyc(2);
    @(negedge clk);
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk) ext <= 1'b1;
      cyc(10);
      @(posedge clk) ext <= 1'b0;
      cyc(10);
    end
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset_and_map;
    for (int i = 0; i < 8; i++) rdc("reset value", I_CT + i[9:0], 8'h00);
    wr(I_CT, 8'h02); rdc("ctrl unused", I_CT, 8'h00);
    wr(10'h090, 8'h55, ERR); rdc("unmapped", 10'h090, 8'h00);
    wr(I_CT, 8'h39); rdc("ctrl fields", I_CT, 8'h39);
    wr(I_CT, 8'h00);
  endtask
  task automatic t_wrap16_irq;
    logic [31:0] a, b;
    wr(I_RL, 8'h34); wr(I_RH, 8'h12); wr(I_CL, 8'h80); wr(I_CH, 8'hFF); wr(I_CS, 8'h01);
    wr(I_CT, 8'h04); rdc("no early flag", I_CT, 8'h04);
    cyc(150); rdc("wrap flags", I_CT, 8'hC4);
    wr(I_CT, 8'hC0); rd(I_CL, a); cyc(20); rd(I_CL, b);
    chk("halted count", a, b);
    rdc("reloaded high", I_CH, 8'h12);
    rdc("flags kept", I_CT, 8'hC0);
    rdc("irq status", I_ST, 8'h01); chk_irq(1'b0);
    wr(I_MK, 8'h01); chk_irq(1'b1);
    wr(I_CT, 8'h00); rdc("flags cleared", I_CT, 8'h00);
    wr(I_ST, 8'h01); chk_irq(1'b0);
  endtask
  task automatic t_split;
    logic [31:0] d;
    wr(I_RL, 8'h80); wr(I_RH, 8'h77); wr(I_CL, 8'hF0); wr(I_CH, 8'hFE); wr(I_CS, 8'h03);
    wr(I_MK, 8'h02); wr(I_CT, 8'h28); cyc(100);
    rdc("gated high", I_CH, 8'hFE);
    rd(I_CL, d); chk("low reload", 32'h1, {31'h0, d[7]});
    rdc("split flags", I_CT, 8'h68); rdc("low event", I_ST, 8'h02);
    chk_irq(1'b1);
    wr(I_CT, 8'h6C); cyc(20); rdc("high runs", I_CT, 8'hEC);
    wr(I_CT, 8'h00); wr(I_ST, 8'h03); wr(I_MK, 8'h00); chk_irq(1'b0);
  endtask
  task automatic t_ext;
    logic [31:0] d;
    wr(I_RL, 8'h00); wr(I_RH, 8'h00); wr(I_CL, 8'h00); wr(I_CH, 8'h00); wr(I_CS, 8'h00);
    wr(I_CT, 8'h14); pulses(8); cyc(10);
    rdc("capture flag", I_CT, 8'h94); rdc("capture high", I_RH, 8'h00);
    rd(I_RL, d); chk("capture low", 32'h1, {31'h0, d[7:0] != 8'h00});
    wr(I_CT, 8'h00); wr(I_RL, 8'h00); wr(I_CL, 8'h00);
    wr(I_CT, 8'h05); pulses(16); cyc(10);
    rdc("ext div8 count", I_CL, 8'h02);
    rdc("no capture", I_RL, 8'h00);
    wr(I_CT, 8'h00);
  endtask
  task automatic give_verdict;
    $display("checks %0d, errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    cyc(10);
    rst_b <= 1'b1;
    cyc(2);
    t_reset_and_map();
    t_wrap16_irq();
    t_split();
    t_ext();
    give_verdict();
  end
endmodule // t3cs_top_test
